// ===== ccr_pkg.sv
package ccr_pkg;
  // Register byte offsets
  localparam logic [11:0] OFS_INT_SET      = 12'h304;
  localparam logic [11:0] OFS_INT_DISABLE  = 12'h308;
  localparam logic [11:0] OFS_STATUS       = 12'h310;
  localparam logic [11:0] OFS_STATUS_CLR   = 12'h314;
  localparam logic [11:0] OFS_OUTCOME      = 12'h400;
  localparam logic [11:0] OFS_ON_OFF       = 12'h500;
  localparam logic [11:0] OFS_PIN_SEL      = 12'h504;
  localparam logic [11:0] OFS_REF_SEL      = 12'h508;
  localparam logic [11:0] OFS_EXT_REF_SEL  = 12'h50C;
  localparam logic [11:0] OFS_THRESHOLDS   = 12'h530;
  localparam logic [11:0] OFS_MODE         = 12'h534;
  localparam logic [11:0] OFS_HYST         = 12'h538;
  localparam logic [11:0] OFS_INPUT_CURRENT_SOURCE_SELECT      = 12'h53C;
  // Field positions, threshold code width and event count
  localparam int          THR_LO_POS       = 0;
  localparam int          THR_HI_POS       = 8;
  localparam int          THR_W            = 6;
  localparam int          MODE_MAIN_POS    = 8;
  localparam int          EVT_N            = 3;
  // Event bit positions in status and enable (DOWN, UP, CROSS)
  localparam int          EVT_DOWN         = 0;
  localparam int          EVT_UP           = 1;
  localparam int          EVT_CROSS        = 2;
  // Interrupt enable bit position of each event (READY is bit 0)
  localparam int          IEN_OFS          = 1;
  // Encodings and reset values
  localparam logic [1:0]  ON_OFF_DISABLED  = 2'h0;
  localparam logic [1:0]  ON_OFF_ENABLED   = 2'h2;
  localparam logic [2:0]  REF_RESET        = 3'h4;
  localparam logic [2:0]  REF_INT_1P2      = 3'h0;
  localparam logic [2:0]  REF_INT_1P8      = 3'h1;
  localparam logic [2:0]  REF_INT_2P4      = 3'h2;
  localparam logic [2:0]  REF_SUPPLY       = 3'h4;
  localparam logic [2:0]  REF_EXTERNAL     = 3'h5;
  localparam logic [1:0]  SPEED_LOW        = 2'h0;
  localparam logic [1:0]  SPEED_NORMAL     = 2'h1;
  localparam logic [1:0]  SPEED_HIGH       = 2'h2;
  localparam logic        MAIN_SINGLE      = 1'h0;
  localparam logic        MAIN_DIFF        = 1'h1;
  localparam logic        HYST_OFF         = 1'h0;
  localparam logic        HYST_ON          = 1'h1;
  localparam logic [31:0] ZERO_WORD        = 32'h00000000;
  // Threshold steps per full reference
  localparam int          THR_STEPS        = 64;
  // Comparator front-end states
  typedef enum logic [1:0] {
    CCR_OFF = 2'b01,
    CCR_RUN = 2'b10
  } ccr_state_t;
endpackage

// ===== ccr_latch.sv
`timescale 1ns/100ps
// Samples the comparator output on the sample strike and reports crossings
module ccr_latch (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic ce_i,
  input  wire logic run_i,       // Comparator switched on
  input  wire logic sample_i,    // Sample task pulse
  input  wire logic cmp_i,       // Raw comparator decision
  output logic      result_o,    // Latched outcome
  output logic      up_o,        // Upward crossing pulse
  output logic      down_o       // Downward crossing pulse
);
  logic result_q, result_d;
  logic up_q, up_d;
  logic down_q, down_d;

  // Capture on sample, flag transitions
  always_comb
  begin
    result_d = result_q;
    up_d     = 1'b0;
    down_d   = 1'b0;
    if (run_i && sample_i)
    begin
      result_d = cmp_i; // see [RULE2] see [RULE3]
      up_d     = cmp_i & ~result_q;
      down_d   = ~cmp_i & result_q;
    end
  end

  // State registers
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      result_q <= 1'b0;
      up_q     <= 1'b0;
      down_q   <= 1'b0;
    end
    else if (ce_i)
    begin
      result_q <= result_d;
      up_q     <= up_d;
      down_q   <= down_d;
    end
  end

  assign result_o = result_q;
  assign up_o     = up_q;
  assign down_o   = down_q;

  // Checks
  property p_capture;
    @(posedge clk_i) disable iff (!rstn_i)
    (ce_i && run_i && sample_i) |=> (result_q == $past(cmp_i));
  endproperty
  a_capture: assert property (p_capture) else $error("outcome not captured"); // see [RULE2]

  property p_hold;
    @(posedge clk_i) disable iff (!rstn_i)
    !(run_i && sample_i && ce_i) |=> $stable(result_q);
  endproperty
  a_hold: assert property (p_hold) else $error("outcome changed without sample"); // see [RULE2]

  property p_up;
    @(posedge clk_i) disable iff (!rstn_i)
    up_q |-> (result_q == 1'b1);
  endproperty
  a_up: assert property (p_up) else $error("up pulse with low outcome"); // see [RULE3]
endmodule

// ===== ccr_top.sv
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
// Contract
// [RULE1] Writing one disables DOWN/UP/CROSS interrupt
// [RULE2] Outcome captured on sample task
// [RULE3] Outcome 0 below, 1 above
// [RULE4] Enable field 0 off, 2 on
// [RULE5] Reference select codes, reset four
// [RULE6] Two 6-bit threshold codes, reset zero
// [RULE7] Speed/power field and main-mode bit
// [RULE8] Hysteresis bit enables differential hysteresis
// [RULE9] Single-ended: lower threshold while above
// [RULE10] Single-ended: hysteresis bit ignored
module ccr_top #(
  parameter int THR_BITS = ccr_pkg::THR_W   // Threshold code width
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,          // Freezes all state when low
  input  wire logic [11:0] addr_i,        // Byte address
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,       // Valid the cycle after rd_i
  input  wire logic        sample_i,      // Sample task pulse
  input  wire logic        cmp_i,         // Comparator decision, 1 = above
  output logic             comp_on_o,     // Analog core on
  output logic       [2:0] ref_sel_o,
  output logic       [5:0] neg_code_o,    // Threshold code on negative input
  output logic       [1:0] speed_o,
  output logic             diff_o,
  output logic             hyst_o,        // Differential hysteresis active
  output logic             result_o,
  output logic             irq_o          // Level interrupt
);
  // Refuse code widths that the negative input port cannot carry
  if (THR_BITS < 1 || THR_BITS > 6)
  begin : g_thr_check
    $error("threshold code width out of range");
  end

  // Address match, shared by the write and read decoders
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  // Configuration registers
  logic [1:0]                on_off_q, on_off_d;        // On/off field
  logic [31:0]               pin_sel_q, pin_sel_d;      // Pin select, stored for software only
  logic [2:0]                ref_q, ref_d;              // Reference source
  logic [31:0]               ext_ref_q, ext_ref_d;      // External reference select, stored only
  logic [THR_BITS-1:0]       thr_lo_q, thr_lo_d;        // Lower threshold code
  logic [THR_BITS-1:0]       thr_hi_q, thr_hi_d;        // Upper threshold code
  logic [1:0]                speed_q, speed_d;          // Speed/power select
  logic                      main_q, main_d;            // Main mode, 1 = differential
  logic                      hyst_q, hyst_d;            // Hysteresis enable bit
  logic [31:0]               isrc_q, isrc_d;            // Current source select, stored only
  // Interrupt state
  logic [ccr_pkg::EVT_N-1:0] ien_q, ien_d;              // Interrupt enables
  logic [ccr_pkg::EVT_N-1:0] stat_q, stat_d;            // Sticky events
  logic [ccr_pkg::EVT_N-1:0] evt;                       // Event pulses this cycle
  logic [ccr_pkg::EVT_N-1:0] dis_mask;                  // Bits written to the disable view
  // Front-end state
  ccr_pkg::ccr_state_t       state_q, state_d;          // Off or running
  logic                      run;                       // Sampling allowed
  logic                      result_w;                  // Latched outcome
  logic                      up_w;                      // Upward crossing pulse
  logic                      down_w;                    // Downward crossing pulse
  // Output registers
  logic [31:0]               rdata_q, rdata_d;          // Read data, one cycle only
  logic                      comp_on_q, comp_on_d;      // Core switched on
  logic [2:0]                ref_out_q, ref_out_d;      // Reference to the core
  logic [5:0]                neg_code_q, neg_code_d;    // Code on the negative input
  logic [1:0]                speed_out_q, speed_out_d;  // Speed/power to the core
  logic                      diff_q, diff_d;            // Differential mode
  logic                      hyst_act_q, hyst_act_d;    // Hysteresis really active
  logic                      irq_q, irq_d;              // Level interrupt
  // Write strobes, one per register
  logic                      wr_on_off;
  logic                      wr_pin_sel;
  logic                      wr_ref;
  logic                      wr_ext_ref;
  logic                      wr_thr;
  logic                      wr_mode;
  logic                      wr_hyst;
  logic                      wr_isrc;
  logic                      wr_int_set;
  logic                      wr_int_dis;
  logic                      wr_stat_clr;

  // Decode a write strobe per register
  assign wr_on_off   = wr_i && hit(addr_i, ccr_pkg::OFS_ON_OFF);
  assign wr_pin_sel  = wr_i && hit(addr_i, ccr_pkg::OFS_PIN_SEL);
  assign wr_ref      = wr_i && hit(addr_i, ccr_pkg::OFS_REF_SEL);
  assign wr_ext_ref  = wr_i && hit(addr_i, ccr_pkg::OFS_EXT_REF_SEL);
  assign wr_thr      = wr_i && hit(addr_i, ccr_pkg::OFS_THRESHOLDS);
  assign wr_mode     = wr_i && hit(addr_i, ccr_pkg::OFS_MODE);
  assign wr_hyst     = wr_i && hit(addr_i, ccr_pkg::OFS_HYST);
  assign wr_isrc     = wr_i && hit(addr_i, ccr_pkg::OFS_INPUT_CURRENT_SOURCE_SELECT);
  assign wr_int_set  = wr_i && hit(addr_i, ccr_pkg::OFS_INT_SET);
  assign wr_int_dis  = wr_i && hit(addr_i, ccr_pkg::OFS_INT_DISABLE);
  assign wr_stat_clr = wr_i && hit(addr_i, ccr_pkg::OFS_STATUS_CLR);

  // Register writes; no access ever stalls the bus
  always_comb
  begin
    on_off_d  = on_off_q;
    pin_sel_d = pin_sel_q;
    ref_d     = ref_q;
    ext_ref_d = ext_ref_q;
    thr_lo_d  = thr_lo_q;
    thr_hi_d  = thr_hi_q;
    speed_d   = speed_q;
    main_d    = main_q;
    hyst_d    = hyst_q;
    isrc_d    = isrc_q;
    if (wr_on_off)
      on_off_d = wdata_i[1:0];                               // see [RULE4]
    if (wr_pin_sel)
      pin_sel_d = wdata_i;
    if (wr_ref)
      ref_d = wdata_i[2:0];                                  // see [RULE5]
    if (wr_ext_ref)
      ext_ref_d = wdata_i;
    if (wr_thr)
    begin
      thr_lo_d = wdata_i[ccr_pkg::THR_LO_POS +: THR_BITS];   // see [RULE6]
      thr_hi_d = wdata_i[ccr_pkg::THR_HI_POS +: THR_BITS];   // see [RULE6]
    end
    if (wr_mode)
    begin
      speed_d = wdata_i[1:0];                                // see [RULE7]
      main_d  = wdata_i[ccr_pkg::MODE_MAIN_POS];             // see [RULE7]
    end
    // Stored in either mode; only differential mode acts on it
    if (wr_hyst)
      hyst_d = wdata_i[0];                                   // see [RULE8]
    if (wr_isrc)
      isrc_d = wdata_i;
  end

  // Front end runs only while the enable field held the on code one cycle earlier
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ccr_pkg::CCR_OFF:
      begin
        if (on_off_q == ccr_pkg::ON_OFF_ENABLED)
          state_d = ccr_pkg::CCR_RUN;                        // see [RULE4]
      end
      ccr_pkg::CCR_RUN:
      begin
        if (on_off_q != ccr_pkg::ON_OFF_ENABLED)
          state_d = ccr_pkg::CCR_OFF;                        // see [RULE4]
      end
      default:
        state_d = ccr_pkg::CCR_OFF;
    endcase
  end
  // Samples taken while off are dropped
  assign run = (state_q == ccr_pkg::CCR_RUN);

  // Outcome latch and crossing detector
  ccr_latch ccr_latch_i (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .ce_i     (ce_i),
    .run_i    (run),
    .sample_i (sample_i),
    .cmp_i    (cmp_i),
    .result_o (result_w),
    .up_o     (up_w),
    .down_o   (down_w)
  );

  // Crossing events; CROSS merges both directions
  assign evt[ccr_pkg::EVT_DOWN]  = down_w;
  assign evt[ccr_pkg::EVT_UP]    = up_w;
  assign evt[ccr_pkg::EVT_CROSS] = up_w | down_w;
  // Per event enable and sticky status; a new event beats a clear in the same cycle
  for (genvar i = 0; i < ccr_pkg::EVT_N; i++)
  begin : g_evt
    assign ien_d[i]  = (wr_int_set && wdata_i[ccr_pkg::IEN_OFS + i]) ? 1'b1 :
                       (wr_int_dis && wdata_i[ccr_pkg::IEN_OFS + i]) ? 1'b0 : ien_q[i]; // see [RULE1]
    assign stat_d[i] = evt[i] | (stat_q[i] & ~(wr_stat_clr & wdata_i[ccr_pkg::IEN_OFS + i]));
  end
  assign dis_mask = wdata_i[ccr_pkg::IEN_OFS +: ccr_pkg::EVT_N];  // Only read by a check

  // Output next values from next register values, except neg_code_d, which uses the current thresholds, mode and outcome
  always_comb
  begin
    comp_on_d   = (on_off_d == ccr_pkg::ON_OFF_ENABLED);    // see [RULE4]
    ref_out_d   = ref_d;                                    // see [RULE5]
    speed_out_d = speed_d;                                  // see [RULE7]
    diff_d      = (main_d == ccr_pkg::MAIN_DIFF);           // see [RULE7]
    // Hysteresis bit only counts in differential mode
    hyst_act_d  = (main_d == ccr_pkg::MAIN_DIFF) && (hyst_d == ccr_pkg::HYST_ON); // see [RULE8] see [RULE10]
    irq_d       = |(stat_d & ien_d);
    // Single-ended: lower threshold while above, upper while below
    neg_code_d  = 6'(thr_hi_q);
    if (main_q == ccr_pkg::MAIN_SINGLE && result_w)
      neg_code_d = 6'(thr_lo_q);                            // see [RULE9]
  end

  // Read data for one cycle after the strobe, zero otherwise
  always_comb
  begin
    rdata_d = ccr_pkg::ZERO_WORD;
    if (rd_i)
    begin
      if (hit(addr_i, ccr_pkg::OFS_OUTCOME))
        rdata_d[0] = result_w;                              // see [RULE2] see [RULE3]
      else if (hit(addr_i, ccr_pkg::OFS_ON_OFF))
        rdata_d[1:0] = on_off_q;                            // see [RULE4]
      else if (hit(addr_i, ccr_pkg::OFS_PIN_SEL))
        rdata_d = pin_sel_q;
      else if (hit(addr_i, ccr_pkg::OFS_REF_SEL))
        rdata_d[2:0] = ref_q;                               // see [RULE5]
      else if (hit(addr_i, ccr_pkg::OFS_EXT_REF_SEL))
        rdata_d = ext_ref_q;
      else if (hit(addr_i, ccr_pkg::OFS_THRESHOLDS))
      begin
        rdata_d[ccr_pkg::THR_LO_POS +: THR_BITS] = thr_lo_q;  // see [RULE6]
        rdata_d[ccr_pkg::THR_HI_POS +: THR_BITS] = thr_hi_q;  // see [RULE6]
      end
      else if (hit(addr_i, ccr_pkg::OFS_MODE))
      begin
        rdata_d[1:0]                    = speed_q;           // see [RULE7]
        rdata_d[ccr_pkg::MODE_MAIN_POS] = main_q;            // see [RULE7]
      end
      else if (hit(addr_i, ccr_pkg::OFS_HYST))
        rdata_d[0] = hyst_q;                                // see [RULE8]
      else if (hit(addr_i, ccr_pkg::OFS_INPUT_CURRENT_SOURCE_SELECT))
        rdata_d = isrc_q;
      // Both enable views read back the same bits
      else if (hit(addr_i, ccr_pkg::OFS_INT_SET) || hit(addr_i, ccr_pkg::OFS_INT_DISABLE))
        rdata_d[ccr_pkg::IEN_OFS +: ccr_pkg::EVT_N] = ien_q;  // see [RULE1]
      else if (hit(addr_i, ccr_pkg::OFS_STATUS))
        rdata_d[ccr_pkg::IEN_OFS +: ccr_pkg::EVT_N] = stat_q;
    end
  end

  // Register and interrupt state; clock enable low freezes everything
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      on_off_q  <= ccr_pkg::ON_OFF_DISABLED;
      pin_sel_q <= ccr_pkg::ZERO_WORD;
      ref_q     <= ccr_pkg::REF_RESET;
      ext_ref_q <= ccr_pkg::ZERO_WORD;
      thr_lo_q  <= '0;
      thr_hi_q  <= '0;
      speed_q   <= ccr_pkg::SPEED_LOW;
      main_q    <= ccr_pkg::MAIN_SINGLE;
      hyst_q    <= ccr_pkg::HYST_OFF;
      isrc_q    <= ccr_pkg::ZERO_WORD;
      state_q   <= ccr_pkg::CCR_OFF;
      ien_q     <= '0;
      stat_q    <= '0;
    end
    else if (ce_i)
    begin
      on_off_q  <= on_off_d;
      pin_sel_q <= pin_sel_d;
      ref_q     <= ref_d;
      ext_ref_q <= ext_ref_d;
      thr_lo_q  <= thr_lo_d;
      thr_hi_q  <= thr_hi_d;
      speed_q   <= speed_d;
      main_q    <= main_d;
      hyst_q    <= hyst_d;
      isrc_q    <= isrc_d;
      state_q   <= state_d;
      ien_q     <= ien_d;
      stat_q    <= stat_d;
    end
  end

  // Output flip-flops, so every pin comes straight from a register
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rdata_q     <= ccr_pkg::ZERO_WORD;
      comp_on_q   <= 1'b0;
      ref_out_q   <= ccr_pkg::REF_RESET;
      neg_code_q  <= 6'h00;
      speed_out_q <= ccr_pkg::SPEED_LOW;
      diff_q      <= 1'b0;
      hyst_act_q  <= 1'b0;
      irq_q       <= 1'b0;
    end
    else if (ce_i)
    begin
      rdata_q     <= rdata_d;
      comp_on_q   <= comp_on_d;
      ref_out_q   <= ref_out_d;
      neg_code_q  <= neg_code_d;
      speed_out_q <= speed_out_d;
      diff_q      <= diff_d;
      hyst_act_q  <= hyst_act_d;
      irq_q       <= irq_d;
    end
  end
  // Pins
  assign rdata_o    = rdata_q;
  assign comp_on_o  = comp_on_q;
  assign ref_sel_o  = ref_out_q;
  assign neg_code_o = neg_code_q;
  assign speed_o    = speed_out_q;
  assign diff_o     = diff_q;
  assign hyst_o     = hyst_act_q;
  assign result_o   = result_w;
  assign irq_o      = irq_q;

  // Checks
  property p_irq_level;
    @(posedge clk_i) disable iff (!rstn_i)
    irq_q == |(stat_q & ien_q);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level mismatch"); // see [RULE1]
  property p_disable;
    @(posedge clk_i) disable iff (!rstn_i)
    (ce_i && wr_int_dis) |=> ((ien_q & $past(dis_mask)) == '0);
  endproperty
  a_disable: assert property (p_disable) else $error("interrupt not disabled"); // see [RULE1]
  property p_se_neg;
    @(posedge clk_i) disable iff (!rstn_i)
    (ce_i && main_q == ccr_pkg::MAIN_SINGLE && result_w) |=> (neg_code_q == 6'($past(thr_lo_q)));
  endproperty
  a_se_neg: assert property (p_se_neg) else $error("lower threshold not selected"); // see [RULE9]
  property p_hyst_se;
    @(posedge clk_i) disable iff (!rstn_i)
    !diff_q |-> !hyst_act_q;
  endproperty
  a_hyst_se: assert property (p_hyst_se) else $error("hysteresis active in single-ended mode"); // see [RULE10]
  // Main scenarios
  c_up_event: cover property (@(posedge clk_i) disable iff (!rstn_i) up_w);
  c_down_event: cover property (@(posedge clk_i) disable iff (!rstn_i) down_w);
  c_irq_rise: cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(irq_q));
endmodule

// ===== tb.sv
`timescale 1ns/100ps
module tb;
  logic        clk_i, rstn_i, ce_i, wr_i, rd_i, sample_i, cmp_i;
  logic [11:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic        comp_on_o, diff_o, hyst_o, result_o, irq_o;
  logic [2:0]  ref_sel_o;
  logic [5:0]  neg_code_o;
  logic [1:0]  speed_o;
  int          fails, tests_run;
  // Write a word, read it back
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} ccr_row_t;
  ccr_row_t    rows [11];
  ccr_top ccr_top_i (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sample_i(sample_i),
    .cmp_i(cmp_i), .comp_on_o(comp_on_o), .ref_sel_o(ref_sel_o), .neg_code_o(neg_code_o),
    .speed_o(speed_o), .diff_o(diff_o), .hyst_o(hyst_o), .result_o(result_o), .irq_o(irq_o));
  // Free running 40 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      fails++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask
  // One strobe cycle; read data is settled 1 ns into the next cycle
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= w; rd_i <= ~w; addr_i <= a; wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0; rd_i <= 1'b0;
    #1;
  endtask
  // Sample strike, then let the latch settle
  task automatic strike(input logic c);
    @(posedge clk_i);
    cmp_i <= c; sample_i <= 1'b1;
    @(posedge clk_i);
    sample_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic report_and_stop;
    if (fails == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Hang guard, well beyond the hundred or so cycles used
  initial
  begin
    #50000;
    fails++;
    report_and_stop();
  end
  initial
  begin
    rows = '{'{ccr_pkg::OFS_ON_OFF, 32'h2, 32'h2}, '{ccr_pkg::OFS_REF_SEL, 32'h0, 32'h0},
      '{ccr_pkg::OFS_REF_SEL, 32'h1, 32'h1}, '{ccr_pkg::OFS_REF_SEL, 32'h2, 32'h2},
      '{ccr_pkg::OFS_REF_SEL, 32'h5, 32'h5}, '{ccr_pkg::OFS_THRESHOLDS, 32'h3F01, 32'h3F01},
      '{ccr_pkg::OFS_MODE, 32'h1, 32'h1}, '{ccr_pkg::OFS_MODE, 32'h102, 32'h102},
      '{ccr_pkg::OFS_HYST, 32'h1, 32'h1}, '{ccr_pkg::OFS_INT_SET, 32'hE, 32'hE},
      '{ccr_pkg::OFS_INT_DISABLE, 32'h4, 32'hA}};
    {rstn_i, ce_i, wr_i, rd_i, sample_i, cmp_i} = 6'h00;
    addr_i = 12'h000; wdata_i = 32'h0;
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1; ce_i <= 1'b1;
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 32'h0);
      chk("row", rdata_o, rows[i].e);
    end
    chk("hyst", 32'({diff_o, hyst_o, comp_on_o}), 32'h7);
    chk("ref_pin", 32'(ref_sel_o), 32'h5);
    chk("speed_pin", 32'(speed_o), 32'h2);
    bus(1'b1, ccr_pkg::OFS_MODE, 32'h2);
    repeat (2) @(posedge clk_i);
    #1;
    chk("hyst_se", 32'({diff_o, hyst_o}), 32'h0);
    // Clock enable low must drop a write
    ce_i <= 1'b0;
    bus(1'b1, ccr_pkg::OFS_REF_SEL, 32'h0);
    ce_i <= 1'b1;
    bus(1'b0, ccr_pkg::OFS_REF_SEL, 32'h0);
    chk("ce_hold", rdata_o, 32'h5);
    strike(1'b1);
    bus(1'b0, ccr_pkg::OFS_OUTCOME, 32'h0);
    chk("above", rdata_o, 32'h1);
    chk("neg_lo", 32'(neg_code_o), 32'h01);
    bus(1'b0, ccr_pkg::OFS_STATUS, 32'h0);
    chk("stat_up", rdata_o, 32'hC);
    chk("irq_on", 32'(irq_o), 32'h1);
    bus(1'b1, ccr_pkg::OFS_INT_DISABLE, 32'h8);
    chk("irq_off", 32'(irq_o), 32'h0);
    cmp_i <= 1'b0;
    bus(1'b0, ccr_pkg::OFS_OUTCOME, 32'h0);
    chk("held", rdata_o, 32'h1);
    strike(1'b0);
    bus(1'b0, ccr_pkg::OFS_OUTCOME, 32'h0);
    chk("below", rdata_o, 32'h0);
    chk("neg_hi", 32'(neg_code_o), 32'h3F);
    chk("irq_down", 32'(irq_o), 32'h1);
    bus(1'b1, ccr_pkg::OFS_STATUS_CLR, 32'hE);
    chk("irq_clr", 32'(irq_o), 32'h0);
    bus(1'b0, ccr_pkg::OFS_STATUS, 32'h0);
    chk("stat_clr", rdata_o, 32'h0);
    // Mid-run reset returns defaults
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    #1;
    chk("on_rst", 32'(comp_on_o), 32'h0);
    chk("irq_rst", 32'(irq_o), 32'h0);
    bus(1'b0, ccr_pkg::OFS_REF_SEL, 32'h0);
    chk("ref_rst", rdata_o, 32'h4);
    bus(1'b0, ccr_pkg::OFS_THRESHOLDS, 32'h0);
    chk("th_rst", rdata_o, 32'h0);
    bus(1'b0, ccr_pkg::OFS_INT_DISABLE, 32'h0);
    chk("ien_rst", rdata_o, 32'h0);
    report_and_stop();
  end
endmodule
